//--- rtl/qhsi_cfg.svh
// Constants of the quad UART host strobe and interrupt port
`ifndef QHSI_CFG_SVH
`define QHSI_CFG_SVH

// ************************************************
// Bus mode coding of the mode select pin
// ************************************************
`define QHSI_MODE_SEP 1'b1
`define QHSI_MODE_COMB 1'b0

// ************************************************
// Pin sample vector layout
// ************************************************
`define QHSI_PIN_W 17
`define QHSI_PIN_DATA_LSB 0
`define QHSI_PIN_ADDR_LSB 8
`define QHSI_PIN_RD 11
`define QHSI_PIN_WR 12
`define QHSI_PIN_CS 13
`define QHSI_PIN_RST 14
`define QHSI_PIN_FORCE 15
`define QHSI_PIN_MODE 16
// Sampler reset level: strobes idle high, force select low like its pull-down
`define QHSI_PIN_IDLE 17'h17fff

// ************************************************
// Control port offsets
// ************************************************
`define QHSI_OFS_STATUS 4'h0
`define QHSI_OFS_MASK 4'h4
`define QHSI_OFS_STATE 4'h8

// ************************************************
// Event bits of status and mask
// ************************************************
`define QHSI_EV_READ 0
`define QHSI_EV_WRITE 1
`define QHSI_EV_IRQ 2
`define QHSI_EV_W 3
`define QHSI_MASK_RST 3'h0

// ************************************************
// Timing: strobe edge to data drive, in cycles
// ************************************************
`define QHSI_RD_LAT 3

`endif

//--- rtl/qhsi_pkg.sv
// Types of the quad UART host strobe and interrupt port
package qhsi_pkg;

   // Access sequencer states
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_RD_WAIT = 2'b01,
      ACC_RD_CAP = 2'b10,
      ACC_DRIVE = 2'b11
   } qhsi_acc_e;

   // Request toward the channel registers
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } qhsi_req_s;

   // Per channel interrupt sources
   typedef struct packed {
      logic [3:0] modem_ctrl_oe;
      logic [3:0] irq_enable;
      logic [3:0] pending;
   } qhsi_irqsrc_s;

endpackage : qhsi_pkg

//--- rtl/qhsi_port.sv
// Host strobe port and interrupt pin control of a quad UART
`timescale 1ns/100ps
`default_nettype none
`include "qhsi_cfg.svh"

// Summary of operation
// - Force select high-active, only in separate mode
// - Force high enables all four irq outputs
// - Force low: modem bit 3 enables outputs
// - Combined mode ignores force select
// - Read strobe fall drives selected register
// - Write strobe fall stores bus data
// - Combined mode: write pin is direction
// - Combined mode: one request replaces channel A
// - All channel requests merged onto it
// - Mode low: reset pin acts inverted
// - Separate mode: irq high when enabled and pending
module qhsi_port (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic [2:0] addr,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chip_sel_n,
   input wire logic reset_pin,
   input wire logic irq_force_select,
   input wire logic bus_mode_sel,
   output logic [3:0] chan_irq,
   output logic [3:0] chan_irq_oe,
   output qhsi_pkg::qhsi_req_s reg_req,
   input wire logic [7:0] reg_rdata,
   input wire qhsi_pkg::qhsi_irqsrc_s irq_src,
   output logic dev_reset,
   input wire logic [3:0] ctl_addr,
   input wire logic [7:0] ctl_wdata,
   input wire logic ctl_wr,
   input wire logic ctl_rd,
   output logic [7:0] ctl_rdata,
   output logic irq
);
   import qhsi_pkg::*;

   // ************************************************
   // Helper functions
   // ************************************************

   // High for one sample when a level went from one to zero
   function automatic logic fell(input logic prev, input logic cur);
      fell = prev & ~cur;
   endfunction : fell

   // ************************************************
   // Pin synchronisers
   // ************************************************

   logic [`QHSI_PIN_W-1:0] pin_raw; // Raw pin levels
   logic [`QHSI_PIN_W-1:0] pin_s1_q; // First stage, read by second only
   logic [`QHSI_PIN_W-1:0] pin_s2_q; // Stable samples
   logic [`QHSI_PIN_W-1:0] pin_s3_q; // Previous stable samples

   assign pin_raw = {bus_mode_sel, irq_force_select, reset_pin, chip_sel_n,
                     write_strobe_n, read_strobe_n, addr, data_in};

   // Two flops, then a history flop for edges
   always_ff @(posedge clock) begin
      if (rst) begin
         pin_s1_q <= `QHSI_PIN_IDLE; // No false force after reset
         pin_s2_q <= `QHSI_PIN_IDLE;
         pin_s3_q <= `QHSI_PIN_IDLE;
      end else if (ce) begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // ************************************************
   // Decoded pin views
   // ************************************************

   logic mode_sep; // Separate strobe mode selected
   logic force_s; // Synchronised force select
   logic rd_s; // Synchronised read strobe, low active
   logic rw_s; // Write pin, direction in combined mode
   logic cs_s; // Synchronised chip select, low active
   logic [2:0] addr_s; // Synchronised address
   logic [7:0] data_s; // Synchronised data
   logic rd_start; // A read begins
   logic wr_start; // A write begins
   logic rd_active; // Host still asks for read data

   assign mode_sep = (pin_s2_q[`QHSI_PIN_MODE] == `QHSI_MODE_SEP);
   assign force_s = pin_s2_q[`QHSI_PIN_FORCE];
   assign rd_s = pin_s2_q[`QHSI_PIN_RD];
   assign rw_s = pin_s2_q[`QHSI_PIN_WR];
   assign cs_s = pin_s2_q[`QHSI_PIN_CS];
   assign addr_s = pin_s2_q[`QHSI_PIN_ADDR_LSB +: 3];
   assign data_s = pin_s2_q[`QHSI_PIN_DATA_LSB +: 8];

   // Start of an access in either bus style
   always_comb begin
      if (mode_sep) begin
         rd_start = fell(pin_s3_q[`QHSI_PIN_RD], rd_s);
         wr_start = fell(pin_s3_q[`QHSI_PIN_WR], rw_s);
         rd_active = ~rd_s;
      end else begin
         // Direction sampled with the chip select edge
         rd_start = fell(pin_s3_q[`QHSI_PIN_CS], cs_s) & rw_s;
         wr_start = fell(pin_s3_q[`QHSI_PIN_CS], cs_s) & ~rw_s;
         rd_active = ~cs_s & rw_s;
      end
   end

   // ************************************************
   // Access sequencer
   // ************************************************

   qhsi_acc_e acc_q; // Sequencer state
   qhsi_req_s req_q; // Request to the channel registers
   logic [7:0] dout_q; // Read data held on the bus
   logic doe_q; // Bus drive enable

   // Walks a read through request, data and drive
   always_ff @(posedge clock) begin
      if (rst) begin
         acc_q <= ACC_IDLE;
         req_q <= '0;
         dout_q <= 8'h00;
         doe_q <= 1'b0;
      end else if (ce) begin
         req_q.rd <= 1'b0;
         req_q.wr <= 1'b0;
         case (acc_q)
            ACC_IDLE: begin
               doe_q <= 1'b0;
               if (rd_start) begin
                  // Ask for the register picked by the address
                  req_q.rd <= 1'b1;
                  req_q.addr <= addr_s;
                  acc_q <= ACC_RD_WAIT;
               end else if (wr_start) begin
                  // Store the host byte into the picked register
                  req_q.wr <= 1'b1;
                  req_q.addr <= addr_s;
                  req_q.wdata <= data_s;
               end
            end
            ACC_RD_WAIT: begin
               // Register answers one cycle after the request
               acc_q <= ACC_RD_CAP;
            end
            ACC_RD_CAP: begin
               // Catch the answer and drive it out
               dout_q <= reg_rdata;
               doe_q <= 1'b1;
               acc_q <= ACC_DRIVE;
            end
            ACC_DRIVE: begin
               // Release as soon as the strobe goes away
               if (!rd_active) begin
                  doe_q <= 1'b0;
                  acc_q <= ACC_IDLE;
               end
            end
            default: begin
               doe_q <= 1'b0;
               acc_q <= ACC_IDLE;
            end
         endcase
      end
   end

   assign data_out = dout_q;
   assign data_oe = doe_q;
   assign reg_req = req_q;

   // ************************************************
   // Device reset pin
   // ************************************************

   logic dev_rst_q; // Reset toward the channels

   // Polarity follows the bus mode
   always_ff @(posedge clock) begin
      if (rst) begin
         dev_rst_q <= 1'b1;
      end else if (ce) begin
         dev_rst_q <= mode_sep ? pin_s2_q[`QHSI_PIN_RST]
                               : ~pin_s2_q[`QHSI_PIN_RST];
      end
   end

   assign dev_reset = dev_rst_q;

   // ************************************************
   // Interrupt pins
   // ************************************************

   logic [3:0] want; // Enabled and pending per channel
   logic any_want; // Some channel asks for service
   logic [3:0] cirq_q; // Pin levels
   logic [3:0] coe_q; // Pin drive enables

   assign want = irq_src.irq_enable & irq_src.pending;
   assign any_want = |want;

   // Three-state channel pins or one merged request
   always_ff @(posedge clock) begin
      if (rst) begin
         cirq_q <= 4'h0;
         coe_q <= 4'h0;
      end else if (ce) begin
         if (mode_sep) begin
            // Force select only counts here
            if (force_s) begin
               coe_q <= 4'hf;
            end else begin
               coe_q <= irq_src.modem_ctrl_oe;
            end
            cirq_q <= want;
         end else begin
            // Channel A pin pulls low for any request
            coe_q <= {3'h0, any_want};
            cirq_q <= 4'h0;
         end
      end
   end

   assign chan_irq = cirq_q;
   assign chan_irq_oe = coe_q;

   // ************************************************
   // Event status, mask and interrupt
   // ************************************************

   logic [`QHSI_EV_W-1:0] stat_q; // Sticky events
   logic [`QHSI_EV_W-1:0] mask_q; // Event enables
   logic [`QHSI_EV_W-1:0] ev; // Events this cycle
   logic merged_q; // Previous merged request
   logic irq_q; // Interrupt level
   logic [7:0] crd_q; // Control read data

   assign ev = {any_want & ~merged_q, wr_start, rd_start};

   // Events set, written ones clear, set wins
   always_ff @(posedge clock) begin
      if (rst) begin
         stat_q <= '0;
         merged_q <= 1'b0;
      end else if (ce) begin
         merged_q <= any_want;
         if (ctl_wr && ctl_addr == `QHSI_OFS_STATUS) begin
            stat_q <= (stat_q & ~ctl_wdata[`QHSI_EV_W-1:0]) | ev;
         end else begin
            stat_q <= stat_q | ev;
         end
      end
   end

   // Mask register
   always_ff @(posedge clock) begin
      if (rst) begin
         mask_q <= `QHSI_MASK_RST;
      end else if (ce && ctl_wr && ctl_addr == `QHSI_OFS_MASK) begin
         mask_q <= ctl_wdata[`QHSI_EV_W-1:0];
      end
   end

   // Level interrupt from unmasked events
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   // Control read data, valid the cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         crd_q <= 8'h00;
      end else if (ce) begin
         crd_q <= 8'h00;
         if (ctl_rd) begin
            case (ctl_addr)
               `QHSI_OFS_STATUS: crd_q <= {5'h00, stat_q};
               `QHSI_OFS_MASK: crd_q <= {5'h00, mask_q};
               `QHSI_OFS_STATE: crd_q <= {3'h0, any_want, dev_rst_q,
                                          force_s, mode_sep, doe_q};
               default: crd_q <= 8'h00;
            endcase
         end
      end
   end

   assign ctl_rdata = crd_q;
   assign irq = irq_q;

   // ************************************************
   // Assertions
   // ************************************************

   a_force_all_on: assert property (@(posedge clock) disable iff (rst)
      (ce && mode_sep && force_s) |=> (coe_q == 4'hf))
      else $error("force select did not enable all irq pins");
   a_mcr_gating: assert property (@(posedge clock) disable iff (rst)
      (ce && mode_sep && !force_s) |=> (coe_q == $past(irq_src.modem_ctrl_oe)))
      else $error("irq enables do not follow modem bit 3");
   a_force_ignored: assert property (@(posedge clock) disable iff (rst)
      (ce && !mode_sep) |=> (coe_q[3:1] == 3'h0))
      else $error("combined mode drives channel pins");
   a_read_drive: assert property (@(posedge clock) disable iff (rst)
      (ce && mode_sep && rd_start) ##1 ce ##1 ce |=> (doe_q && req_q.addr == $past(addr_s, 3)))
      else $error("read strobe did not drive data");
   a_write_store: assert property (@(posedge clock) disable iff (rst)
      (ce && mode_sep && wr_start && acc_q == ACC_IDLE && !rd_start)
      |=> (req_q.wr && req_q.wdata == $past(data_s)))
      else $error("write strobe did not store data");
   a_dir_write: assert property (@(posedge clock) disable iff (rst)
      (ce && !mode_sep && acc_q == ACC_IDLE && fell(pin_s3_q[`QHSI_PIN_CS], cs_s))
      |=> (req_q.wr == !$past(rw_s)) && (req_q.rd == $past(rw_s)))
      else $error("direction pin misread");
   a_merged_irq: assert property (@(posedge clock) disable iff (rst)
      (ce && !mode_sep) |=> (coe_q[0] == $past(any_want) && !cirq_q[0]))
      else $error("merged request wrong");
   a_reset_polarity: assert property (@(posedge clock) disable iff (rst)
      ce |=> (dev_rst_q == ($past(mode_sep) ~^ $past(pin_s2_q[`QHSI_PIN_RST]))))
      else $error("device reset polarity wrong");
   a_irq_level: assert property (@(posedge clock) disable iff (rst)
      (ce && mode_sep) |=> (cirq_q == $past(irq_src.irq_enable & irq_src.pending)))
      else $error("channel irq level wrong");
   a_bus_release: assert property (@(posedge clock) disable iff (rst)
      (acc_q == ACC_IDLE || acc_q == ACC_RD_WAIT) |-> !doe_q)
      else $error("data bus driven outside read");

endmodule : qhsi_port
`default_nettype wire

//--- sim/qhsi_host_model.sv
// Host processor model on the parallel strobe bus
`timescale 1ns/100ps
`default_nettype none
module qhsi_host_model (
   input wire logic clock,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output wire logic [7:0] data_in,
   output logic [2:0] addr,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic chip_sel_n
);
   logic drive = 1'b0; // Host drives the data bus
   logic [7:0] host_d = 8'h00; // Byte driven by the host
   logic [7:0] last_q = 8'h00; // Last bus level, floats to its inverse

   // Idle strobes at time zero
   initial begin
      addr = 3'h0;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      chip_sel_n = 1'b1;
   end

   // Bus level from host, device or nobody
   assign data_in = drive ? host_d : ((data_oe === 1'b1) ? data_out : ~last_q);
   always @(posedge clock) begin
      last_q <= data_in;
   end

   // ************************************************
   // One byte access, separate or combined strobes
   // ************************************************
   task automatic access(input logic sep, input logic wr, input logic [2:0] a,
                         input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      host_d <= d;
      drive <= wr;
      write_strobe_n <= sep | ~wr; // Direction in combined mode
      repeat (2) @(posedge clock);
      if (!sep) begin
         chip_sel_n <= 1'b0;
      end else if (wr) begin
         write_strobe_n <= 1'b0;
      end else begin
         read_strobe_n <= 1'b0;
      end
      repeat (8) @(posedge clock);
      chip_sel_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      repeat (6) @(posedge clock);
      drive <= 1'b0;
   endtask : access
endmodule : qhsi_host_model
`default_nettype wire

//--- sim/quad_uart_host_strobe_irq_ctrl_bench.sv
// Self-checking testbench of the quad UART host strobe and interrupt port
`timescale 1ns/100ps
`default_nettype none
`include "qhsi_cfg.svh"
module quad_uart_host_strobe_irq_ctrl_bench;
   import qhsi_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1; // Clock enable, held on except in the clock enable test
   logic [7:0] data_in, data_out, ctl_rdata;
   logic data_oe, read_strobe_n, write_strobe_n, chip_sel_n, dev_reset, irq;
   logic reset_pin = 1'b0, irq_force_select = 1'b0, bus_mode_sel = 1'b1;
   logic ctl_wr = 1'b0, ctl_rd = 1'b0, ctl_rd_prev = 1'b0, oe_prev = 1'b0, seen;
   logic [7:0] reg_rdata = 8'h00, ctl_wdata = 8'h00, d;
   logic [2:0] addr, a;
   logic [3:0] chan_irq, chan_irq_oe, act, ctl_addr = 4'h0;
   qhsi_req_s reg_req;
   qhsi_irqsrc_s irq_src = '0, src;
   logic [7:0] bank [8]; // Channel registers behind the port
   logic [7:0] mirror [8]; // Bytes the bench wrote
   logic [12:0] expq [$]; // Expected results, oldest first
   logic [12:0] got;
   int n_fail = 0, tests_run = 0, cycles = 0;

   always #5 clock = ~clock;

   qhsi_port u_dut (.clock(clock), .rst(rst), .ce(ce), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .addr(addr), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .chip_sel_n(chip_sel_n), .reset_pin(reset_pin),
      .irq_force_select(irq_force_select), .bus_mode_sel(bus_mode_sel),
      .chan_irq(chan_irq), .chan_irq_oe(chan_irq_oe), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .irq_src(irq_src), .dev_reset(dev_reset),
      .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
      .ctl_rdata(ctl_rdata), .irq(irq));

   qhsi_host_model u_host (.clock(clock), .data_out(data_out), .data_oe(data_oe),
      .data_in(data_in), .addr(addr), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .chip_sel_n(chip_sel_n));

   // Register bank answers the cycle after a read request, junk otherwise
   always @(posedge clock) begin
      if (reg_req.wr) begin
         bank[reg_req.addr] <= reg_req.wdata;
      end
      reg_rdata <= reg_req.rd ? bank[reg_req.addr] : ~reg_rdata;
   end

   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         end_of_test();
      end
   end

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic check(input logic [12:0] g, input logic [12:0] e);
      tests_run = tests_run + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check

   task automatic end_of_test();
      if (expq.size() != 0) begin
         n_fail = n_fail + 1;
      end
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   task automatic settle();
      repeat (4) @(posedge clock);
      @(negedge clock);
   endtask : settle

   task automatic ctl_write(input logic [3:0] ca, input logic [7:0] cd);
      @(posedge clock);
      ctl_addr <= ca;
      ctl_wdata <= cd;
      ctl_wr <= 1'b1;
      @(posedge clock);
      ctl_wr <= 1'b0;
   endtask : ctl_write

   task automatic ctl_read(input logic [3:0] ca, input logic [7:0] e);
      expq.push_back({2'h2, 3'h0, e});
      @(posedge clock);
      ctl_addr <= ca;
      ctl_rd <= 1'b1;
      @(posedge clock);
      ctl_rd <= 1'b0;
   endtask : ctl_read

   task automatic host_xfer(input logic sep, input logic wr, input logic [2:0] ha,
                            input logic [7:0] hd);
      if (wr) begin
         mirror[ha] = hd;
         expq.push_back({2'h0, ha, hd});
      end else begin
         expq.push_back({2'h3, ha, 8'h00});
         expq.push_back({2'h1, 3'h0, mirror[ha]});
      end
      u_host.access(sep, wr, ha, hd);
   endtask : host_xfer

   // Monitor takes the oldest note whenever a result shows
   always @(negedge clock) begin
      seen = 1'b1;
      if (reg_req.wr === 1'b1) begin
         got = {2'h0, reg_req.addr, reg_req.wdata};
      end else if (reg_req.rd === 1'b1) begin
         got = {2'h3, reg_req.addr, 8'h00};
      end else if (data_oe === 1'b1 && oe_prev === 1'b0) begin
         got = {2'h1, 3'h0, data_out};
      end else if (ctl_rd_prev) begin
         got = {2'h2, 3'h0, ctl_rdata};
      end else begin
         seen = 1'b0;
      end
      if (seen) begin
         check(got, (expq.size() == 0) ? 13'h1fff : expq.pop_front());
      end
      oe_prev = data_oe;
      ctl_rd_prev = ctl_rd;
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      void'($urandom(32'hbe15));
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      settle();
      check({9'h0, data_oe, chan_irq_oe[2:0]}, 13'h0000);
      $display("test reset done");
      ctl_write(`QHSI_OFS_STATUS, 8'h07);
      for (int i = 0; i < 4; i++) begin
         a = 3'($urandom);
         d = 8'($urandom);
         host_xfer(1'b1, 1'b1, a, d);
         @(negedge clock);
         check({12'h0, data_oe}, 13'h0000);
         host_xfer(1'b1, 1'b0, a, 8'h00);
      end
      $display("test separate bus done");
      ctl_read(`QHSI_OFS_STATUS, 8'h03);
      ctl_read(`QHSI_OFS_STATE, 8'h02);
      ctl_read(4'hc, 8'h00);
      ctl_write(`QHSI_OFS_MASK, 8'h01);
      settle();
      check({12'h0, irq}, 13'h0001);
      ctl_write(`QHSI_OFS_MASK, 8'h00);
      settle();
      check({12'h0, irq}, 13'h0000);
      ctl_write(`QHSI_OFS_MASK, 8'h01);
      ctl_write(`QHSI_OFS_STATUS, 8'h01);
      settle();
      check({12'h0, irq}, 13'h0000);
      ctl_read(`QHSI_OFS_STATUS, 8'h02);
      ctl_read(`QHSI_OFS_MASK, 8'h01);
      $display("test status irq done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         src = 12'($urandom);
         if (!i[0]) begin
            src.modem_ctrl_oe = 4'hf;
         end
         irq_src <= src;
         irq_force_select <= i[1];
         bus_mode_sel <= i[0];
         reset_pin <= ~i[0];
         settle();
         act = src.irq_enable & src.pending;
         if (i[0]) begin
            check({5'h0, chan_irq_oe, chan_irq}, {5'h0, i[1] ? 4'hf : src.modem_ctrl_oe, act});
         end else begin
            check({8'h0, chan_irq_oe, chan_irq[0]}, {8'h0, 3'h0, |act, 1'b0});
         end
      end
      $display("test irq pins done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         bus_mode_sel <= i[1];
         reset_pin <= i[0];
         settle();
         check({12'h0, dev_reset}, {12'h0, i[1] ~^ i[0]});
      end
      $display("test reset pin done");
      @(posedge clock);
      ce <= 1'b0; // Freeze all state
      reset_pin <= 1'b0;
      settle();
      check({12'h0, dev_reset}, 13'h0001);
      @(posedge clock);
      ce <= 1'b1;
      settle();
      check({12'h0, dev_reset}, 13'h0000);
      $display("test clock enable done");
      @(posedge clock);
      bus_mode_sel <= 1'b0;
      reset_pin <= 1'b1;
      settle();
      a = 3'($urandom);
      d = 8'($urandom);
      host_xfer(1'b0, 1'b1, a, d);
      host_xfer(1'b0, 1'b0, a, 8'h00);
      settle();
      $display("test combined bus done");
      end_of_test();
   end
endmodule : quad_uart_host_strobe_irq_ctrl_bench
`default_nettype wire
